// [core/rlp_pkg.sv]
// Shared constants and carrier types for the reset and low-power controller.
package rlp_pkg;

  // Oscillator period of the clock input, in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS  = 5;
  // Least reset hold, in oscillator periods (two machine cycles).
  localparam int unsigned RST_HOLD_OSC   = 24;
  // The clock input is the oscillator, so one period is one cycle.
  localparam int unsigned RST_HOLD_CYC   = RST_HOLD_OSC;
  // Oscillator restart and settle time after a power-down wake, in ms.
  localparam int unsigned SETTLE_MS      = 10;
  // Settle time in cycles; a longest time, so it rounds down.
  localparam int unsigned SETTLE_CYC_DEF =
    (SETTLE_MS * 1000000) / CLK_PERIOD_NS;
  // Width of the settle and reset hold counters.
  localparam int unsigned CNT_W          = 22;
  // Reset values of the mode request bits and the power-off flag.
  localparam logic        IDLE_RST_VAL   = 1'b0;
  localparam logic        PD_RST_VAL     = 1'b0;
  localparam logic        FLAG_RST_VAL   = 1'b1;

  // Controller states.
  typedef enum logic [2:0] {
    RLP_RUN       = 3'b000,
    RLP_IDLE      = 3'b001,
    RLP_IDLE_RST  = 3'b010,
    RLP_PDOWN     = 3'b011,
    RLP_WAKE      = 3'b100,
    RLP_WAKE_HIGH = 3'b101,
    RLP_RESET     = 3'b110
  } rlp_state_t;

  // Mode request and flag writes from the core, one-cycle strobes.
  typedef struct packed {
    logic idle_set;   // Request idle mode.
    logic pd_set;     // Request power-down mode.
    logic flag_we;    // Write strobe for the power-off flag.
    logic flag_wdata; // Value written to the power-off flag.
  } rlp_core_req_t;

  // External interrupt configuration as held by the core.
  typedef struct packed {
    logic a_en;       // ext_irq_a enabled.
    logic a_level;    // ext_irq_a level-sensitive.
    logic b_en;       // ext_irq_b enabled.
    logic b_level;    // ext_irq_b level-sensitive.
  } rlp_irq_cfg_t;

  // Registered status visible to software and the core.
  typedef struct packed {
    logic idle_bit;        // Idle request bit.
    logic pd_bit;          // Power-down request bit.
    logic power_off_flag;  // Cold start indicator.
  } rlp_status_t;

endpackage : rlp_pkg

// [core/rlp_ctrl.sv]
// Reset recognition, clock division and low-power mode sequencing.
`timescale 1ns/1ps
`default_nettype none

module rlp_ctrl #(
  parameter int unsigned SETTLE_CYC = rlp_pkg::SETTLE_CYC_DEF  // Wake settle.
) (
  input  wire logic                   clock,          // Oscillator input.
  input  wire logic                   rst,            // Power-on reset.
  input  wire logic                   reset_pin,      // External reset pin.
  input  wire logic                   ext_irq_a,      // External irq a pin.
  input  wire logic                   ext_irq_b,      // External irq b pin.
  input  wire logic                   irq_pending,    // Any enabled irq.
  input  wire rlp_pkg::rlp_irq_cfg_t  irq_cfg,        // Ext irq settings.
  input  wire rlp_pkg::rlp_core_req_t core_req,       // Core mode writes.
  output logic                        port_reset,     // Ports to reset state.
  output logic                        core_reset,     // Internal reset.
  output logic                        osc_enable,     // Oscillator runs.
  output logic                        core_clk_en,    // Core phase enable.
  output logic                        periph_clk_en,  // Peripheral enable.
  output logic                        ram_inhibit,    // Block RAM access.
  output logic                        irq_resume,     // Wake to handler.
  output rlp_pkg::rlp_status_t        status          // Registered status.
);
  import rlp_pkg::*;

  rlp_state_t         state_q;
  rlp_state_t         state_d;
  logic               div_q;
  logic               div_d;
  logic [CNT_W-1:0]   hold_q;
  logic [CNT_W-1:0]   hold_d;
  logic [CNT_W-1:0]   settle_q;
  logic [CNT_W-1:0]   settle_d;
  logic               resume_q;
  logic               resume_d;
  rlp_status_t        stat_q;
  rlp_status_t        stat_d;
  logic               osc_ok;
  logic               wake_low;
  logic               hold_done;
  logic               settle_done;

  localparam logic [CNT_W-1:0] HOLD_LAST   = CNT_W'(RST_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  // Asynchronous port reset.
  // No clock is involved, so ports reach their reset state even when the
  // oscillator is stopped in power-down.
  assign port_reset = reset_pin | rst;

  // Level wake detection.
  // Of the irq pins, only enabled, level-sensitive inputs may wake the part from power-down; the reset pin also wakes it.
  assign wake_low = (irq_cfg.a_en & irq_cfg.a_level & ~ext_irq_a) |
                    (irq_cfg.b_en & irq_cfg.b_level & ~ext_irq_b);

  assign settle_done = (settle_q == SETTLE_LAST);
  assign hold_done   = (hold_q == HOLD_LAST);

  // The oscillator counts as running except while stopped or restarting.
  assign osc_ok = (state_q != RLP_PDOWN) &&
                  !((state_q == RLP_WAKE) && !settle_done);

  assign osc_enable = (state_q != RLP_PDOWN);

  // Divide-by-two phase.
  // The core and peripheral enables derive from this toggle, so the duty cycle of an
  // external clock on the oscillator input does not matter.
  assign div_d = osc_ok ? ~div_q : div_q;

  // Core halts in idle, peripherals keep their phase.
  // Core runs on while the pending reset is counted out.
  assign core_clk_en   = div_q & osc_ok &
                         ((state_q == RLP_RUN) || (state_q == RLP_IDLE_RST));
  assign periph_clk_en = div_q & osc_ok;

  // RAM is blocked until the reset takes over; the ports are already held in reset by the pin.
  assign ram_inhibit = (state_q == RLP_IDLE_RST);

  assign core_reset = (state_q == RLP_RESET);
  assign irq_resume = resume_q;
  assign status     = stat_q;

  // Next-state logic for the mode sequencer and its counters.
  // Nothing here clears retained state when the clock slows or stops.
  // Idle leaves every register untouched apart from the mode flow.
  always_comb begin
    state_d  = state_q;
    hold_d   = hold_q;
    settle_d = settle_q;
    resume_d = 1'b0;
    stat_d   = stat_q;

    // Count the reset pin while the oscillator runs.
    // A short glitch restarts the count and is ignored.
    if (reset_pin && osc_ok) begin
      if (!hold_done) begin
        hold_d = hold_q + CNT_W'(1);
      end
    end else begin
      hold_d = '0;
    end

    // Software write of the power-off flag.
    if (core_req.flag_we) begin
      stat_d.power_off_flag = core_req.flag_wdata;
    end

    unique case (state_q)
      RLP_RUN: begin
        // Power-down wins over idle when both are requested.
        if (core_req.pd_set) begin
          stat_d.pd_bit   = 1'b1;
          stat_d.idle_bit = core_req.idle_set;
          state_d         = RLP_PDOWN;
        end else if (core_req.idle_set) begin
          stat_d.idle_bit = 1'b1;
          state_d         = RLP_IDLE;
        end
      end
      RLP_IDLE: begin
        if (reset_pin) begin
          state_d = RLP_IDLE_RST;
        end else if (irq_pending) begin
          stat_d.idle_bit = 1'b0;
          resume_d        = 1'b1;
          state_d         = RLP_RUN;
        end
      end
      RLP_IDLE_RST: begin
        // The pin dropped before the hold time; the core stays awake.
        if (!reset_pin) begin
          stat_d.idle_bit = 1'b0;
          state_d         = RLP_RUN;
        end
      end
      RLP_PDOWN: begin
        // Low level or reset restarts the oscillator.
        if (reset_pin || wake_low) begin
          settle_d = '0;
          state_d  = RLP_WAKE;
        end
      end
      RLP_WAKE: begin
        // Wait out the oscillator settle time.
        if (!settle_done) begin
          settle_d = settle_q + CNT_W'(1);
        end else if (!reset_pin) begin
          state_d = RLP_WAKE_HIGH;
        end
      end
      RLP_WAKE_HIGH: begin
        // Return of the pin high completes the exit.
        // No register or RAM is reset on this path.
        // The core enters the handler and then continues in line.
        if (!wake_low) begin
          stat_d.pd_bit   = 1'b0;
          stat_d.idle_bit = 1'b0;
          resume_d        = 1'b1;
          state_d         = RLP_RUN;
        end
      end
      RLP_RESET: begin
        // Internal reset holds for as long as the pin stays high.
        if (!reset_pin) begin
          state_d = RLP_RUN;
        end
      end
      default: begin
        state_d = RLP_RUN;
      end
    endcase

    // Hold time reached: internal reset takes control.
    // Mode bits return to reset values; RAM is never cleared here.
    if (reset_pin && osc_ok && hold_done) begin
      state_d         = RLP_RESET;
      stat_d.idle_bit = IDLE_RST_VAL;
      stat_d.pd_bit   = PD_RST_VAL;
      resume_d        = 1'b0;
    end
  end

  // State registers; of the two resets, only power-on reset sets the power-off flag.
  // Power-up sets the flag.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q  <= RLP_RESET;
      div_q    <= 1'b0;
      hold_q   <= '0;
      settle_q <= '0;
      resume_q <= 1'b0;
      stat_q   <= '{idle_bit: IDLE_RST_VAL, pd_bit: PD_RST_VAL,
                    power_off_flag: FLAG_RST_VAL};
    end else begin
      state_q  <= state_d;
      div_q    <= div_d;
      hold_q   <= hold_d;
      settle_q <= settle_d;
      resume_q <= resume_d;
      stat_q   <= stat_d;
    end
  end

endmodule : rlp_ctrl

`default_nettype wire

// [bench/rlp_ctrl_monitor.sv]
// Concurrent checks on the reset and low-power controller ports.
`timescale 1ns/1ps
`default_nettype none

module rlp_ctrl_monitor (
  input wire logic                   clock,          // Osc.
  input wire logic                   rst,            // Reset.
  input wire logic                   reset_pin,      // Pin.
  input wire logic                   ext_irq_a,      // Irq a.
  input wire logic                   ext_irq_b,      // Irq b.
  input wire logic                   irq_pending,    // Irq.
  input wire rlp_pkg::rlp_irq_cfg_t  irq_cfg,        // Cfg.
  input wire rlp_pkg::rlp_core_req_t core_req,       // Req.
  input wire logic                   port_reset,     // Ports.
  input wire logic                   core_reset,     // Core.
  input wire logic                   osc_enable,     // Osc on.
  input wire logic                   core_clk_en,    // Core.
  input wire logic                   periph_clk_en,  // Periph.
  input wire logic                   ram_inhibit,    // Ram.
  input wire logic                   irq_resume,     // Resume.
  input wire rlp_pkg::rlp_status_t   status          // Status.
);
  import rlp_pkg::*;
  logic [4:0] hi_q;
  logic [4:0] hi_d;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // High pin count; power-down is left out since settling delays it.
  always_comb begin
    hi_d = '0;
    if (reset_pin && osc_enable && !status.pd_bit)
      hi_d = (hi_q == 5'h1f) ? hi_q : hi_q + 5'h1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) hi_q <= '0;
    else hi_q <= hi_d;
  end
  property p_port; reset_pin |-> port_reset; endproperty
  a_port: assert property (p_port) else $error("port reset");
  property p_div; core_clk_en |=> !core_clk_en; endproperty
  a_div: assert property (p_div) else $error("clock div");
  property p_pdosc; $rose(status.pd_bit) |-> !osc_enable; endproperty
  a_pdosc: assert property (p_pdosc) else $error("osc on");
  property p_halt; status.idle_bit && !status.pd_bit && !ram_inhibit
    |-> !core_clk_en; endproperty
  a_halt: assert property (p_halt) else $error("core ran");
  property p_iwake; status.idle_bit && !status.pd_bit && !ram_inhibit &&
    irq_pending && !reset_pin |=> irq_resume && !status.idle_bit; endproperty
  a_iwake: assert property (p_iwake) else $error("idle wake");
  property p_iram; status.idle_bit && !status.pd_bit && !ram_inhibit &&
    reset_pin |=> ram_inhibit; endproperty
  a_iram: assert property (p_iram) else $error("ram open");
  property p_hold; hi_q == 5'd24 |-> core_reset; endproperty
  a_hold: assert property (p_hold) else $error("no reset");
  property p_clr; core_reset |-> !status.idle_bit && !status.pd_bit;
  endproperty
  a_clr: assert property (p_clr) else $error("mode kept");
  property p_pwake; status.pd_bit && !osc_enable && !ext_irq_a &&
    irq_cfg.a_en && irq_cfg.a_level |=> osc_enable; endproperty
  a_pwake: assert property (p_pwake) else $error("pd wake");
  property p_flag; core_req.flag_we
    |=> status.power_off_flag == $past(core_req.flag_wdata); endproperty
  a_flag: assert property (p_flag) else $error("flag write");
endmodule : rlp_ctrl_monitor

bind rlp_ctrl rlp_ctrl_monitor rlp_ctrl_monitor_i (.clock, .rst, .reset_pin,
  .ext_irq_a, .ext_irq_b, .irq_pending, .irq_cfg, .core_req, .port_reset,
  .core_reset, .osc_enable, .core_clk_en, .periph_clk_en, .ram_inhibit,
  .irq_resume, .status);
`default_nettype wire

// [bench/rlp_ext_model.sv]
// External reset source and interrupt pins facing the controller.
`timescale 1ns/1ps
`default_nettype none

module rlp_ext_model (
  input  wire logic clock,      // Osc.
  output var  logic reset_pin,  // Reset pin.
  output var  logic ext_irq_a,  // Irq a pin.
  output var  logic ext_irq_b   // Irq b pin.
);
  // Released pins rest at their pull level: reset low, irqs high.
  initial begin
    reset_pin = 1'b0;
    ext_irq_a = 1'b1;
    ext_irq_b = 1'b1;
  end
  task automatic hold_reset(input int n);
    @(posedge clock);
    reset_pin <= 1'b1;
    repeat (n) @(posedge clock);
    reset_pin <= 1'b0;
    #1;
  endtask : hold_reset
  // Level wake hold on pin a, or on pin b when sel_b is set.
  task automatic pull_irq(input int n, input logic sel_b);
    @(posedge clock);
    if (sel_b) begin
      ext_irq_b <= 1'b0;
    end else begin
      ext_irq_a <= 1'b0;
    end
    repeat (n) @(posedge clock);
    ext_irq_a <= 1'b1;
    ext_irq_b <= 1'b1;
    #1;
  endtask : pull_irq
endmodule : rlp_ext_model
`default_nettype wire

// [bench/reset_low_power_control_tb_top.sv]
// Directed bench for the reset and low-power controller.
`timescale 1ns/1ps
`default_nettype none

module reset_low_power_control_tb_top;
  import rlp_pkg::*;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          irq_pending = 1'b0;
  rlp_irq_cfg_t  irq_cfg = '0;
  rlp_core_req_t core_req = '0;
  logic          reset_pin, ext_irq_a, ext_irq_b, port_reset, core_reset;
  logic          osc_enable, core_clk_en, periph_clk_en, ram_inhibit;
  logic          irq_resume, p0;
  rlp_status_t   status;
  int            fail_count = 0;
  int            samples_checked = 0;
  always #2.5 clock = ~clock;
  rlp_ext_model rlp_ext_model_i (.clock, .reset_pin, .ext_irq_a, .ext_irq_b);
  // Short settle keeps the wake walk within a few cycles.
  rlp_ctrl #(.SETTLE_CYC(8)) rlp_ctrl_i (.clock, .rst, .reset_pin,
    .ext_irq_a, .ext_irq_b, .irq_pending, .irq_cfg, .core_req, .port_reset,
    .core_reset, .osc_enable, .core_clk_en, .periph_clk_en, .ram_inhibit,
    .irq_resume, .status);
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // One-cycle core strobe; returns after the taking edge has landed.
  task automatic req(input rlp_core_req_t r);
    @(posedge clock);
    core_req <= r;
    @(posedge clock);
    core_req <= '0;
    #1;
  endtask : req
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
  initial begin
    tick(5);
    chk({port_reset, status}, 4'h9);
    @(posedge clock) rst <= 1'b0;
    tick(2);
    req('{1'b0, 1'b0, 1'b1, 1'b0});
    chk(status.power_off_flag, 1'b0);
    req('{1'b1, 1'b0, 1'b0, 1'b0});
    p0 = periph_clk_en;
    chk({status.idle_bit, core_clk_en}, 2'b10);
    tick(1);
    chk({p0 | periph_clk_en, core_clk_en}, 2'b10);
    chk(status, 3'b100);
    @(posedge clock) irq_pending <= 1'b1;
    tick(1);
    chk({irq_resume, status.idle_bit}, 2'b10);
    @(posedge clock) irq_pending <= 1'b0;
    for (int n = 23; n < 25; n++) begin
      rlp_ext_model_i.hold_reset(n);
      chk(core_reset, n == 24);
      tick(4);
    end
    req('{1'b1, 1'b0, 1'b0, 1'b0});
    fork rlp_ext_model_i.hold_reset(30); join_none
    // The pin reaches the ports before any clock edge has seen it.
    tick(1);
    chk({port_reset, ram_inhibit}, 2'b10);
    tick(1);
    chk({ram_inhibit, port_reset}, 2'b11);
    tick(26);
    chk({core_reset, status}, 4'h8);
    tick(6);
    @(posedge clock) irq_cfg <= 4'b1000;
    req('{1'b1, 1'b1, 1'b0, 1'b0});
    chk({status, osc_enable}, 4'hc);
    rlp_ext_model_i.pull_irq(4, 1'b0);
    chk(osc_enable, 1'b0);
    @(posedge clock) irq_cfg <= 4'b1100;
    rlp_ext_model_i.pull_irq(12, 1'b0);
    for (int i = 0; i < 40 && irq_resume !== 1'b1; i++) tick(1);
    chk({irq_resume, status}, 4'h8);
    tick(4);
    // Pin b wakes the part; pin a is disabled and must not.
    @(posedge clock) irq_cfg <= 4'b0011;
    req('{1'b0, 1'b1, 1'b0, 1'b0});
    rlp_ext_model_i.pull_irq(4, 1'b0);
    chk({status, osc_enable}, 4'h4);
    rlp_ext_model_i.pull_irq(12, 1'b1);
    for (int i = 0; i < 40 && irq_resume !== 1'b1; i++) tick(1);
    chk({irq_resume, status}, 4'h8);
    tick(4);
    // Reset wake: settle first, then the full hold count.
    req('{1'b0, 1'b1, 1'b0, 1'b0});
    rlp_ext_model_i.hold_reset(32);
    chk({core_reset, status}, 4'h8);
    tick(2);
    // A pin pulse too short to reset leaves idle without a reset.
    req('{1'b1, 1'b0, 1'b0, 1'b0});
    rlp_ext_model_i.hold_reset(5);
    chk({ram_inhibit, core_reset}, 2'b10);
    tick(1);
    chk({ram_inhibit, core_reset, status.idle_bit}, 3'b000);
    tick(2);
    // A second power-on reset marks a cold start again.
    @(posedge clock) rst <= 1'b1;
    tick(2);
    chk({core_reset, status}, 4'h9);
    @(posedge clock) rst <= 1'b0;
    tick(2);
    chk({core_reset, status}, 4'h1);
    tick(4);
    end_sim();
  end
endmodule : reset_low_power_control_tb_top
`default_nettype wire
